/* File: rxosr_pkg.sv */
// Constants, field layouts and carrier types for the receive overhead status bank.
// Assumes one system clock shared by the processor port and the detectors.
// What this block does
// - Line bit 7 mirrors live pointer loss.
// - Line bit 6 latches protection byte change.
// - Line bits 5,4 mirror alarm, remote defect.
// - Line bits 3,2 latch parity, far-end errors.
// - Line bit 1 writable line datalink enable.
// - Line bit 0 writable section datalink enable.
// - Event bits report since last read, cleared.
// - Condition bits mirror detectors, unaffected by reads.
// - Path bits 7,6 mirror alarm, remote defect.
// - Path bits 5,4 latch parity, far-end errors.
// - Path bits 3,2 mirror mismatch, unequipped.
// - Reserved bits read zero.
// - Protection register zero in local-area variants.
// - Protection bit 4 latches switching failure.
// - Protection bits 1,0 mirror failure, degradation.
package rxosr_pkg;

  // Register offsets on the processor port
  localparam logic [7:0] LINE_OFS = 8'h46;
  localparam logic [7:0] PATH_OFS = 8'h47;
  localparam logic [7:0] APS_OFS  = 8'h4a;

  // Line overhead status bit positions
  localparam int LN_LOP_BIT   = 7;
  localparam int LN_PROTECTION_BYTES_CHANGED_BIT  = 6;
  localparam int LN_AIS_BIT   = 5;
  localparam int LN_RDI_BIT   = 4;
  localparam int LN_B2_BIT    = 3;
  localparam int LN_FEBE_BIT  = 2;
  localparam int LN_LDL_BIT   = 1;
  localparam int LN_SDL_BIT   = 0;

  // Path overhead status bit positions
  localparam int PT_AIS_BIT   = 7;
  localparam int PT_RDI_BIT   = 6;
  localparam int PT_B3_BIT    = 5;
  localparam int PT_FEBE_BIT  = 4;
  localparam int PT_PLM_BIT   = 3;
  localparam int PT_UNEQ_BIT  = 2;

  // Protection switch status bit positions
  localparam int AP_PROTECTION_SWITCH_FAILURE_BIT  = 4;
  localparam int AP_SF_BIT    = 1;
  localparam int AP_SD_BIT    = 0;

  // Which bits of each register are sticky events
  localparam logic [7:0] LINE_EVT_MASK = 8'h4c;
  localparam logic [7:0] PATH_EVT_MASK = 8'h30;
  localparam logic [7:0] APS_EVT_MASK  = 8'h10;

  // Reset values and the answer to an unmapped read
  localparam logic [7:0] STICKY_RST = 8'h00;
  localparam logic [7:0] RDATA_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED   = 8'h00;
  localparam logic       CTRL_RST   = 1'b0;

  // One processor access, sampled on clk
  typedef struct packed {
    logic       cs;     // Chip select
    logic       rd;     // Read strobe, one cycle per access
    logic       wr;     // Write strobe, one cycle per access
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
  } rxosr_bus_t;

  // Detector outputs: levels for conditions, one-cycle pulses for events
  typedef struct packed {
    logic pointer_lost;
    logic protection_bytes_changed;
    logic line_alarm_indication;
    logic line_remote_defect;
    logic line_parity_error;
    logic line_far_end_block_error;
    logic path_alarm_indication;
    logic path_remote_defect;
    logic path_parity_error;
    logic path_far_end_block_error;
    logic path_label_mismatch;
    logic path_unequipped;
    logic protection_switch_failure;
    logic signal_failure;
    logic signal_degradation;
  } rxosr_det_t;

endpackage : rxosr_pkg

/* File: rxosr_status_regs.sv */
// Receive line, path and protection status registers on the processor port.
// Assumes bus strobes and detector outputs are synchronous to clk.
`timescale 1ns/1ps

module rxosr_status_regs #(
  parameter bit WAN_VARIANT = 1'b1            // 1 = wide-area part, protection reg active
) (
  input  logic                  clk,                          // System clock, 50 MHz
  input  logic                  rst_n,                        // Async reset, active low
  input  rxosr_pkg::rxosr_bus_t bus_i,                        // Processor access
  input  rxosr_pkg::rxosr_det_t det_i,                        // Detector conditions and events
  output logic [7:0]            rdata_q,                      // Read data, valid with rd_valid_q
  output logic                  rd_valid_q,                   // Read data strobe
  output logic                  line_datalink_rx_enable_q,    // Enables D4..D12 reception
  output logic                  section_datalink_rx_enable_q  // Enables D1..D3 reception
);

  // Register hit decode, shared by read, clear and write paths
  function automatic logic hit(input rxosr_pkg::rxosr_bus_t b, input logic [7:0] ofs);
    hit = b.cs && (b.addr == ofs);
  endfunction : hit

  // Sticky update: a new event always wins over the clearing read
  function automatic logic [7:0] sticky_next(input logic [7:0] q, input logic [7:0] ev,
                                             input logic clr, input logic [7:0] mask);
    sticky_next = ((clr ? rxosr_pkg::STICKY_RST : q) | ev) & mask;
  endfunction : sticky_next

  logic       rd_line;
  logic       rd_path;
  logic       rd_aps;
  logic       wr_line;
  logic [7:0] line_ev;
  logic [7:0] path_ev;
  logic [7:0] aps_ev;
  logic [7:0] line_live;
  logic [7:0] path_live;
  logic [7:0] aps_live;
  logic [7:0] line_evt_q;
  logic [7:0] path_evt_q;
  logic [7:0] aps_evt_q;
  logic [7:0] line_evt_d;
  logic [7:0] path_evt_d;
  logic [7:0] aps_evt_d;
  logic [7:0] rdata_d;

  // Access decode
  assign rd_line = hit(bus_i, rxosr_pkg::LINE_OFS) && bus_i.rd;
  assign rd_path = hit(bus_i, rxosr_pkg::PATH_OFS) && bus_i.rd;
  assign rd_aps  = hit(bus_i, rxosr_pkg::APS_OFS) && bus_i.rd;
  assign wr_line = hit(bus_i, rxosr_pkg::LINE_OFS) && bus_i.wr;

  // Event pulses placed at their register positions
  always_comb begin
    line_ev = 8'h00;
    path_ev = 8'h00;
    aps_ev  = 8'h00;
    line_ev[rxosr_pkg::LN_PROTECTION_BYTES_CHANGED_BIT] = det_i.protection_bytes_changed;
    line_ev[rxosr_pkg::LN_B2_BIT]   = det_i.line_parity_error;
    line_ev[rxosr_pkg::LN_FEBE_BIT] = det_i.line_far_end_block_error;
    path_ev[rxosr_pkg::PT_B3_BIT]   = det_i.path_parity_error;
    path_ev[rxosr_pkg::PT_FEBE_BIT] = det_i.path_far_end_block_error;
    // Local-area parts never see the switching failure
    aps_ev[rxosr_pkg::AP_PROTECTION_SWITCH_FAILURE_BIT]  = WAN_VARIANT && det_i.protection_switch_failure;
  end

  // Live bits: detector conditions read straight through and never stored, plus the two datalink enables
  always_comb begin
    line_live = 8'h00;
    path_live = 8'h00;
    aps_live  = 8'h00;
    line_live[rxosr_pkg::LN_LOP_BIT] = det_i.pointer_lost;
    line_live[rxosr_pkg::LN_AIS_BIT] = det_i.line_alarm_indication;
    line_live[rxosr_pkg::LN_RDI_BIT] = det_i.line_remote_defect;
    line_live[rxosr_pkg::LN_LDL_BIT] = line_datalink_rx_enable_q;
    line_live[rxosr_pkg::LN_SDL_BIT] = section_datalink_rx_enable_q;
    path_live[rxosr_pkg::PT_AIS_BIT]  = det_i.path_alarm_indication;
    path_live[rxosr_pkg::PT_RDI_BIT]  = det_i.path_remote_defect;
    path_live[rxosr_pkg::PT_PLM_BIT]  = det_i.path_label_mismatch;
    path_live[rxosr_pkg::PT_UNEQ_BIT] = det_i.path_unequipped;
    aps_live[rxosr_pkg::AP_SF_BIT] = WAN_VARIANT && det_i.signal_failure;
    aps_live[rxosr_pkg::AP_SD_BIT] = WAN_VARIANT && det_i.signal_degradation;
  end

  // Next sticky state; reads of the register clear only its own events
  assign line_evt_d = sticky_next(line_evt_q, line_ev, rd_line, rxosr_pkg::LINE_EVT_MASK);
  assign path_evt_d = sticky_next(path_evt_q, path_ev, rd_path, rxosr_pkg::PATH_EVT_MASK);
  assign aps_evt_d  = sticky_next(aps_evt_q, aps_ev, rd_aps, rxosr_pkg::APS_EVT_MASK);

  // Sticky event storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_evt_q <= rxosr_pkg::STICKY_RST;
      path_evt_q <= rxosr_pkg::STICKY_RST;
      aps_evt_q  <= rxosr_pkg::STICKY_RST;
    end else begin
      line_evt_q <= line_evt_d;
      path_evt_q <= path_evt_d;
      aps_evt_q  <= aps_evt_d;
    end
  end

  // Datalink enables; only bits 1 and 0 of the line register take writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_datalink_rx_enable_q    <= rxosr_pkg::CTRL_RST;
      section_datalink_rx_enable_q <= rxosr_pkg::CTRL_RST;
    end else if (wr_line) begin
      line_datalink_rx_enable_q    <= bus_i.wdata[rxosr_pkg::LN_LDL_BIT];
      section_datalink_rx_enable_q <= bus_i.wdata[rxosr_pkg::LN_SDL_BIT];
    end
  end

  // Read mux; sticky bits are reported before the clear lands
  always_comb begin
    if (rd_line) begin
      rdata_d = line_live | line_evt_q;
    end else if (rd_path) begin
      rdata_d = path_live | path_evt_q;
    end else if (rd_aps) begin
      rdata_d = aps_live | aps_evt_q;
    end else begin
      rdata_d = rxosr_pkg::UNMAPPED;
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q    <= rxosr_pkg::RDATA_RST;
      rd_valid_q <= 1'b0;
    end else begin
      rdata_q    <= rdata_d;
      rd_valid_q <= bus_i.cs && bus_i.rd;
    end
  end

  // Helper: which register the last read addressed
  logic rd_line_q;
  logic rd_path_q;
  logic rd_aps_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_line_q <= 1'b0;
      rd_path_q <= 1'b0;
      rd_aps_q  <= 1'b0;
    end else begin
      rd_line_q <= rd_line;
      rd_path_q <= rd_path;
      rd_aps_q  <= rd_aps;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Pointer loss read back as it stood at the strobe
  property p_lop_live;
    rd_line |=> rdata_q[rxosr_pkg::LN_LOP_BIT] == $past(det_i.pointer_lost);
  endproperty
  a_lop_live: assert property (p_lop_live) else $error("pointer loss bit wrong");

  // A protection byte change is seen at the next line read
  property p_protection_bytes_changed_seen;
    det_i.protection_bytes_changed ##1 rd_line |=> rdata_q[rxosr_pkg::LN_PROTECTION_BYTES_CHANGED_BIT];
  endproperty
  a_protection_bytes_changed_seen: assert property (p_protection_bytes_changed_seen) else $error("protection change lost");

  // Alarm and remote defect follow the detectors
  property p_line_live;
    rd_line |=> rdata_q[rxosr_pkg::LN_AIS_BIT] == $past(det_i.line_alarm_indication)
             && rdata_q[rxosr_pkg::LN_RDI_BIT] == $past(det_i.line_remote_defect);
  endproperty
  a_line_live: assert property (p_line_live) else $error("line condition bits wrong");

  // Parity error persists until a line read
  property p_b2_hold;
    line_evt_q[rxosr_pkg::LN_B2_BIT] && !rd_line |=> line_evt_q[rxosr_pkg::LN_B2_BIT];
  endproperty
  a_b2_hold: assert property (p_b2_hold) else $error("line parity sticky dropped");

  // A read with no new event clears the far-end bit
  property p_febe_clear;
    rd_line && !det_i.line_far_end_block_error |=> !line_evt_q[rxosr_pkg::LN_FEBE_BIT];
  endproperty
  a_febe_clear: assert property (p_febe_clear) else $error("read did not clear");

  // Event during the clearing read survives it
  property p_set_wins;
    rd_path && det_i.path_parity_error |=> path_evt_q[rxosr_pkg::PT_B3_BIT] ##1 1'b1;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on read");

  // Written enables take effect and hold without writes
  property p_enable_write;
    wr_line ##1 !wr_line [*2] |->
      line_datalink_rx_enable_q == $past(bus_i.wdata[rxosr_pkg::LN_LDL_BIT], 2)
      && section_datalink_rx_enable_q == $past(bus_i.wdata[rxosr_pkg::LN_SDL_BIT], 2);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write wrong");

  // Path conditions mirror the detectors
  property p_path_live;
    rd_path |=> rdata_q[7:6] == $past({det_i.path_alarm_indication, det_i.path_remote_defect})
             && rdata_q[3:2] == $past({det_i.path_label_mismatch, det_i.path_unequipped});
  endproperty
  a_path_live: assert property (p_path_live) else $error("path condition bits wrong");

  // Reserved bits of path and protection reads are zero
  property p_reserved;
    (rd_path_q |-> rdata_q[1:0] == 2'b00) and (rd_aps_q |-> (rdata_q & 8'hec) == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  // Protection register reads zero in a local-area part
  property p_aps_lan;
    rd_aps_q && !WAN_VARIANT |-> rdata_q == 8'h00;
  endproperty
  a_aps_lan: assert property (p_aps_lan) else $error("protection reg not zero");

  // Switching failure reported on the next protection read
  property p_protection_switch_failure;
    WAN_VARIANT && det_i.protection_switch_failure ##1 rd_aps |=>
      rdata_q[rxosr_pkg::AP_PROTECTION_SWITCH_FAILURE_BIT];
  endproperty
  a_protection_switch_failure: assert property (p_protection_switch_failure) else $error("switching failure lost");

  // Signal failure and degradation mirror the detectors
  property p_aps_live;
    WAN_VARIANT && rd_aps |=> rdata_q[1:0] == $past({det_i.signal_failure,
                                                     det_i.signal_degradation});
  endproperty
  a_aps_live: assert property (p_aps_live) else $error("protection condition bits wrong");

  c_line_read_event: cover property (rd_line && line_evt_q != 8'h00);
  c_set_on_read:     cover property (rd_path && det_i.path_parity_error);
  c_enable_write:    cover property (wr_line && bus_i.wdata[1:0] == 2'b11);
  c_aps_read:        cover property (rd_aps && aps_evt_q != 8'h00);

endmodule : rxosr_status_regs

/* File: tb.sv */
// Self-checking bench for the receive overhead status bank, random bus and detector traffic.
// Assumes the design's assertions and covers live in its own files; one clock, async reset.
`timescale 1ns/1ps

module tb;

  logic                  clk;                  // 50 MHz system clock
  logic                  rst_n;                // Async reset, active low
  rxosr_pkg::rxosr_bus_t bus;                  // Processor access driven by the bench
  rxosr_pkg::rxosr_det_t det;                  // Detector levels and pulses
  logic [7:0]            rdata, rdata_lan;     // Read data of both variants
  logic                  rd_valid, rd_valid_lan;
  logic                  ldl, sdl, ldl_lan, sdl_lan;
  int                    errors, cmp_count, cycles;
  logic [7:0]            st_l, st_p, st_a;     // Model sticky bits per register
  logic                  en_l, en_s;           // Model datalink enables
  logic                  exp_valid;
  logic [7:0]            exp_data, exp_lan;
  logic [7:0]            addr_tab [5] = '{8'h46, 8'h47, 8'h4a, 8'h45, 8'h4b};

  // Wide-area part under test
  rxosr_status_regs #(.WAN_VARIANT(1'b1)) uut (
    .clk(clk), .rst_n(rst_n), .bus_i(bus), .det_i(det), .rdata_q(rdata),
    .rd_valid_q(rd_valid), .line_datalink_rx_enable_q(ldl),
    .section_datalink_rx_enable_q(sdl));

  // Local-area part fed the same traffic; its protection register must stay dead
  rxosr_status_regs #(.WAN_VARIANT(1'b0)) uut_lan (
    .clk(clk), .rst_n(rst_n), .bus_i(bus), .det_i(det), .rdata_q(rdata_lan),
    .rd_valid_q(rd_valid_lan), .line_datalink_rx_enable_q(ldl_lan),
    .section_datalink_rx_enable_q(sdl_lan));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // Random access plus detectors: conditions toggle rarely, events pulse sparsely
  task automatic drive_random;
    logic [14:0] flip, pulse, cur;
    int          r;
    for (int i = 0; i < 15; i++) begin
      flip[i]  = ($urandom % 10) == 0;
      pulse[i] = ($urandom % 6) == 0;
    end
    cur = det;
    det = rxosr_pkg::rxosr_det_t'(((cur ^ flip) & 15'h599b) | (pulse & 15'h2664));
    r = $urandom % 3;
    bus.cs    = ($urandom % 4) != 0;
    bus.rd    = (r == 0);        // Never rd with wr, so read data shows settled enables
    bus.wr    = (r == 1);
    bus.addr  = addr_tab[$urandom % 5];
    bus.wdata = 8'($urandom);
  endtask : drive_random

  // Behavioural model: predicts the answer to what is on the pins this cycle
  task automatic model_step;
    logic [7:0] ev_l, ev_p, ev_a, cur_l, cur_p, cur_a;
    ev_l  = {1'b0, det.protection_bytes_changed, 2'h0, det.line_parity_error,
             det.line_far_end_block_error, 2'h0};
    ev_p  = {2'h0, det.path_parity_error, det.path_far_end_block_error, 4'h0};
    ev_a  = {3'h0, det.protection_switch_failure, 4'h0};
    cur_l = {det.pointer_lost, 1'b0, det.line_alarm_indication, det.line_remote_defect,
             2'h0, en_l, en_s} | st_l;
    cur_p = {det.path_alarm_indication, det.path_remote_defect, 2'h0,
             det.path_label_mismatch, det.path_unequipped, 2'h0} | st_p;
    cur_a = {6'h0, det.signal_failure, det.signal_degradation} | st_a;
    exp_valid = bus.cs & bus.rd;
    exp_data  = 8'h00;
    exp_lan   = 8'h00;
    if (exp_valid && bus.addr == rxosr_pkg::LINE_OFS) begin
      exp_data = cur_l;
      exp_lan  = cur_l;
    end
    if (exp_valid && bus.addr == rxosr_pkg::PATH_OFS) begin
      exp_data = cur_p;
      exp_lan  = cur_p;
    end
    if (exp_valid && bus.addr == rxosr_pkg::APS_OFS) exp_data = cur_a;
    // A read clears its events, but a pulse in the same cycle survives
    st_l = (exp_valid && bus.addr == rxosr_pkg::LINE_OFS) ? ev_l : (st_l | ev_l);
    st_p = (exp_valid && bus.addr == rxosr_pkg::PATH_OFS) ? ev_p : (st_p | ev_p);
    st_a = (exp_valid && bus.addr == rxosr_pkg::APS_OFS)  ? ev_a : (st_a | ev_a);
    if (bus.cs && bus.wr && bus.addr == rxosr_pkg::LINE_OFS) {en_l, en_s} = bus.wdata[1:0];
  endtask : model_step

  // Compare both instances with the model one cycle after the pins were sampled
  task automatic check_outputs;
    chk({7'h0, rd_valid}, {7'h0, exp_valid}, "read strobe");
    chk({7'h0, rd_valid_lan}, {7'h0, exp_valid}, "lan read strobe");
    if (exp_valid === 1'b1) begin
      chk(rdata, exp_data, "read data");
      chk(rdata_lan, exp_lan, "lan read data");
    end
    chk({6'h0, ldl, sdl}, {6'h0, en_l, en_s}, "enables");
    chk({6'h0, ldl_lan, sdl_lan}, {6'h0, en_l, en_s}, "lan enables");
  endtask : check_outputs

  // Cut a hang short well past the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      errors++;
      $display("MISMATCH t=%0t run did not finish", $time);
      finish_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    bus   = '0;
    det   = '0;
    st_l  = 8'h00;
    st_p  = 8'h00;
    st_a  = 8'h00;
    en_l  = 1'b0;
    en_s  = 1'b0;
    void'($urandom(32'h20c18b7c));
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    exp_valid = 1'b0;
    check_outputs();
    for (int n = 0; n < 3000; n++) begin
      drive_random();
      model_step();
      @(posedge clk);
      #1;
      check_outputs();
    end
    finish_test();
  end

endmodule : tb
